// *** mlsd_top.sv ***
// Load readout and stall detection with AXI4-Lite registers and interrupt
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "mlsd_defines.svh"
module mlsd_top #(
	parameter int ADDR_W     = 8,                     // Register address width
	parameter int THR_WEIGHT = 16                     // Load counts per threshold step
) (
	input  wire logic               MCLK,
	input  wire logic               RSTN,
	input  wire logic [9:0]         RAW_LOAD,         // Raw measurement, same clock
	input  wire logic               FULLSTEP,         // One pulse per full step, same clock
	output logic [9:0]              LOAD_VALUE,
	output logic                    STALL_OUT,
	output logic                    IRQ,
	input  wire logic [ADDR_W-1:0]  S_AXI_AWADDR,
	input  wire logic               S_AXI_AWVALID,
	output logic                    S_AXI_AWREADY,
	input  wire logic [31:0]        S_AXI_WDATA,
	input  wire logic [3:0]         S_AXI_WSTRB,
	input  wire logic               S_AXI_WVALID,
	output logic                    S_AXI_WREADY,
	output logic [1:0]              S_AXI_BRESP,
	output logic                    S_AXI_BVALID,
	input  wire logic               S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0]  S_AXI_ARADDR,
	input  wire logic               S_AXI_ARVALID,
	output logic                    S_AXI_ARREADY,
	output logic [31:0]             S_AXI_RDATA,
	output logic [1:0]              S_AXI_RRESP,
	output logic                    S_AXI_RVALID,
	input  wire logic               S_AXI_RREADY
);
	import mlsd_pkg::*;

	// Decode a byte address into a one-hot register select
	function automatic mlsd_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
		mlsd_sel_t s;
		s        = '0;
		s.ctrl   = (addr[ADDR_W-1:2] == (ADDR_W-2)'(`MLSD_OFS_CTRL >> 2));
		s.load   = (addr[ADDR_W-1:2] == (ADDR_W-2)'(`MLSD_OFS_LOAD >> 2));
		s.status = (addr[ADDR_W-1:2] == (ADDR_W-2)'(`MLSD_OFS_IRQ_STATUS >> 2));
		s.mask   = (addr[ADDR_W-1:2] == (ADDR_W-2)'(`MLSD_OFS_IRQ_MASK >> 2));
		return s;
	endfunction

	// Expand byte strobes into a bit mask
	function automatic logic [31:0] strb_bits(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// Write channel state
	logic              awready_q;                     // Address channel ready
	logic              wready_q;                      // Data channel ready
	logic              aw_have_q;                     // Address held
	logic              w_have_q;                      // Data held
	logic [ADDR_W-1:0] awaddr_q;                      // Held write address
	logic [31:0]       wdata_q;                       // Held write data
	logic [3:0]        wstrb_q;                       // Held byte strobes
	logic              bvalid_q;                      // Write response pending
	logic [1:0]        bresp_q;                       // Write response code

	// Read channel state
	logic              arready_q;                     // Read address ready
	logic              rvalid_q;                      // Read data pending
	logic [31:0]       rdata_q;                       // Read data register
	logic [1:0]        rresp_q;                       // Read response code

	// Block registers
	mlsd_cfg_t         cfg_q;                         // Threshold and filter mode
	logic [1:0]        mask_q;                        // Interrupt mask
	logic [1:0]        status_q;                      // Sticky interrupt events
	logic [9:0]        load_q;                        // Reported load value
	logic              stall_q;                       // Stall indication
	logic              irq_q;                         // Interrupt output register

	// Handshake and next-state wires
	logic              aw_hs;
	logic              w_hs;
	logic              wr_fire;
	logic              aw_have_d;
	logic              w_have_d;
	logic              bvalid_d;
	logic              ar_hs;
	logic              rvalid_d;
	mlsd_sel_t         wsel;
	mlsd_sel_t         rsel;
	logic              wr_hit;
	logic              rd_hit;
	logic [31:0]       wmask;
	logic [31:0]       cfg_word;
	logic [31:0]       cfg_new;
	logic [31:0]       mask_new;
	logic [31:0]       rd_word;

	// Measurement path wires
	mlsd_meas_t        scaled;
	mlsd_meas_t        filtered;
	logic              stall_d;
	logic              stall_onset;
	logic [1:0]        events;
	logic [1:0]        status_clr;
	logic [1:0]        status_d;
	mlsd_cfg_t         cfg_d;
	logic [1:0]        mask_d;

	// Threshold shift and saturation per full step
	mlsd_scale #(
		.THR_WEIGHT (THR_WEIGHT)
	) u_scale (
		.clk       (MCLK),
		.rst_n     (RSTN),
		.raw       (RAW_LOAD),
		.raw_valid (FULLSTEP),
		.thr       (cfg_q.thr),
		.meas      (scaled)
	);

	// Optional four-step averaging
	mlsd_filter u_filter (
		.clk      (MCLK),
		.rst_n    (RSTN),
		.filt_en  (cfg_q.filt_en),
		.in_meas  (scaled),
		.out_meas (filtered)
	);

	// Write channel handshakes; address and data may come in either order
	assign aw_hs     = S_AXI_AWVALID & awready_q;
	assign w_hs      = S_AXI_WVALID & wready_q;
	assign wr_fire   = aw_have_q & w_have_q;
	assign aw_have_d = (aw_have_q | aw_hs) & ~wr_fire;
	assign w_have_d  = (w_have_q | w_hs) & ~wr_fire;
	assign bvalid_d  = wr_fire | (bvalid_q & ~S_AXI_BREADY);

	// Write decode and byte-lane merge
	assign wsel     = reg_sel(awaddr_q);
	assign wr_hit   = wsel.ctrl | wsel.load | wsel.status | wsel.mask;
	assign wmask    = strb_bits(wstrb_q);
	assign cfg_word = {23'h0, cfg_q.filt_en, 1'b0, cfg_q.thr};
	assign cfg_new  = (cfg_word & ~wmask) | (wdata_q & wmask);
	assign mask_new = ({30'h0, mask_q} & ~wmask) | (wdata_q & wmask);

	// Configuration written by software steers the measurement; one driver for the whole word
	assign cfg_d  = (wr_fire & wsel.ctrl) ?
	                {cfg_new[`MLSD_CTRL_FEN_BIT], cfg_new[`MLSD_CTRL_THR_MSB:`MLSD_CTRL_THR_LSB]} : cfg_q;
	assign mask_d = (wr_fire & wsel.mask) ? mask_new[1:0] : mask_q;

	// Read channel handshake and decode
	assign ar_hs    = S_AXI_ARVALID & arready_q;
	assign rvalid_d = ar_hs | (rvalid_q & ~S_AXI_RREADY);
	assign rsel     = reg_sel(S_AXI_ARADDR);
	assign rd_hit   = rsel.ctrl | rsel.load | rsel.status | rsel.mask;
	assign rd_word  = rsel.ctrl   ? cfg_word :
	                  rsel.load   ? {15'h0, stall_q, 6'h0, load_q} :
	                  rsel.status ? {30'h0, status_q} :
	                  rsel.mask   ? {30'h0, mask_q} : 32'h0000_0000;

	// Stall follows each reported value; zero means a lost step
	assign stall_d     = filtered.valid ? (filtered.value == 10'h000) : stall_q;
	assign stall_onset = stall_d & ~stall_q;

	// Sticky events; a read of the status word clears, a new event wins
	assign events[`MLSD_IRQ_REFRESH_BIT] = filtered.valid;
	assign events[`MLSD_IRQ_STALL_BIT]   = stall_onset;
	assign status_clr = (ar_hs & rsel.status) ? 2'h3 : 2'h0;
	assign status_d   = (status_q & ~status_clr) | events;

	// Write address and data capture
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			if (aw_hs) begin
				awaddr_q <= S_AXI_AWADDR;
			end
			if (w_hs) begin
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end
		end
	end

	// Write ready and response; one write in flight
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `MLSD_RESP_OKAY;
		end else begin
			awready_q <= ~aw_have_d & ~bvalid_d;
			wready_q  <= ~w_have_d & ~bvalid_d;
			bvalid_q  <= bvalid_d;
			if (wr_fire) begin
				// Unmapped addresses answer with an error
				bresp_q <= wr_hit ? `MLSD_RESP_OKAY : `MLSD_RESP_SLVERR;
			end
		end
	end

	// Read data capture; one read in flight
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `MLSD_RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_hs) begin
				rdata_q <= rd_word;
				rresp_q <= rd_hit ? `MLSD_RESP_OKAY : `MLSD_RESP_SLVERR;
			end
		end
	end

	// Configuration and mask registers
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			cfg_q.thr     <= `MLSD_RST_THR;
			cfg_q.filt_en <= `MLSD_RST_FEN;
			mask_q        <= `MLSD_RST_MASK;
		end else begin
			cfg_q  <= cfg_d;
			mask_q <= mask_d;
		end
	end

	// Reported load, stall and interrupt
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			load_q   <= `MLSD_RST_LOAD;
			stall_q  <= 1'b0;
			status_q <= 2'h0;
			irq_q    <= 1'b0;
		end else begin
			if (filtered.valid) begin
				load_q <= filtered.value;
			end
			stall_q  <= stall_d;
			status_q <= status_d;
			irq_q    <= |(status_d & mask_d);
		end
	end

	// Outputs come straight from registers
	assign LOAD_VALUE    = load_q;
	assign STALL_OUT     = stall_q;
	assign IRQ           = irq_q;
	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY  = wready_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_BRESP   = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RDATA   = rdata_q;
	assign S_AXI_RRESP   = rresp_q;
endmodule

// *** mlsd_defines.svh ***
// Register map, field positions, reset values and constants of the load readout block
// What this block does
// - Accept seven-bit signed sensitivity threshold
// - Negative threshold more sensitive, positive less
// - Report ten-bit unsigned load, high means light
// - Unfiltered: refresh load once per full step
// - Filter on: average four, update per four
// - Stall output high when load reads zero, from the first report on (reset gives load zero, stall low)
`ifndef MLSD_DEFINES_SVH
`define MLSD_DEFINES_SVH

// Byte offsets of the register words
`define MLSD_OFS_CTRL        8'h00
`define MLSD_OFS_LOAD        8'h04
`define MLSD_OFS_IRQ_STATUS  8'h08
`define MLSD_OFS_IRQ_MASK    8'h0C

// Control word fields
`define MLSD_CTRL_THR_LSB    0
`define MLSD_CTRL_THR_MSB    6
`define MLSD_CTRL_FEN_BIT    8

// Load word fields
`define MLSD_LOAD_VAL_LSB    0
`define MLSD_LOAD_VAL_MSB    9
`define MLSD_LOAD_STALL_BIT  16

// Interrupt status and mask bits
`define MLSD_IRQ_REFRESH_BIT 0
`define MLSD_IRQ_STALL_BIT   1

// Reset values
`define MLSD_RST_THR         7'h00
`define MLSD_RST_FEN         1'b0
`define MLSD_RST_MASK        2'h0
`define MLSD_RST_LOAD        10'h000

// Full scale of the load value
`define MLSD_LOAD_MAX        10'h3FF
// Measurements averaged in filtered mode
`define MLSD_FILT_COUNT      4

// AXI responses
`define MLSD_RESP_OKAY       2'h0
`define MLSD_RESP_SLVERR     2'h2

`endif

// *** mlsd_pkg.sv ***
// Types shared by the load readout modules
package mlsd_pkg;

	// Software configuration of the measurement
	typedef struct packed {
		logic       filt_en;   // Average over four full steps
		logic [6:0] thr;       // Signed sensitivity threshold
	} mlsd_cfg_t;

	// One load measurement with its strobe
	typedef struct packed {
		logic       valid;     // One-cycle strobe
		logic [9:0] value;     // Unsigned load value
	} mlsd_meas_t;

	// One-hot register select
	typedef struct packed {
		logic mask;
		logic status;
		logic load;
		logic ctrl;
	} mlsd_sel_t;

endpackage

// *** mlsd_scale.sv ***
// Applies the signed threshold to a raw measurement and saturates the result
`timescale 1ns/1ps
`include "mlsd_defines.svh"
module mlsd_scale #(
	parameter int THR_WEIGHT = 16                     // Load counts per threshold step
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [9:0]         raw,              // Raw measurement from the sensing front end
	input  wire logic               raw_valid,        // Full-step strobe
	input  wire logic [6:0]         thr,              // Signed threshold
	output mlsd_pkg::mlsd_meas_t    meas              // Scaled measurement
);
	import mlsd_pkg::*;

	localparam logic signed [12:0] WEIGHT = 13'(THR_WEIGHT);

	logic signed [12:0] thr_ext;                      // Threshold widened to the sum width
	logic signed [12:0] offset;                       // Shift of the measurement range
	logic signed [12:0] sum;                          // Raw value after the shift
	logic [9:0]         sat;                          // Clamped value
	mlsd_meas_t         meas_q;                       // Output register

	assign thr_ext = 13'(signed'(thr));
	// Positive threshold lifts the value, negative pulls it toward zero
	assign offset  = 13'(thr_ext * WEIGHT);
	assign sum     = signed'({3'h0, raw}) + offset;
	// Clamp instead of wrapping
	assign sat     = sum[12] ? 10'h000 :
	                 (sum > 13'sd1023) ? `MLSD_LOAD_MAX : sum[9:0];

	// Register the clamped value on every full step
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meas_q <= '0;
		end else begin
			meas_q.valid <= raw_valid;
			if (raw_valid) begin
				meas_q.value <= sat;
			end
		end
	end

	assign meas = meas_q;
endmodule

// *** mlsd_filter.sv ***
// Optional average over four measurements
`timescale 1ns/1ps
`include "mlsd_defines.svh"
module mlsd_filter (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               filt_en,          // Filtered mode
	input  mlsd_pkg::mlsd_meas_t    in_meas,          // Scaled measurement per full step
	output mlsd_pkg::mlsd_meas_t    out_meas          // Reported measurement
);
	import mlsd_pkg::*;

	logic [11:0] acc_q;                               // Running sum of the current group
	logic [11:0] acc_sum;                             // Sum including the new sample
	logic [1:0]  cnt_q;                               // Samples already in the group
	logic        fen_q;                               // Mode of the group in progress
	logic        group_end;                           // Fourth sample arrives
	mlsd_meas_t  out_q;                               // Output register

	assign acc_sum   = acc_q + {2'h0, in_meas.value};
	assign group_end = in_meas.valid & (cnt_q == 2'(`MLSD_FILT_COUNT - 1));

	// Collect groups of four, or pass every sample through
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_q <= 12'h000;
			cnt_q <= 2'h0;
			fen_q <= 1'b0;
			out_q <= '0;
		end else begin
			fen_q       <= filt_en;
			out_q.valid <= 1'b0;
			if (filt_en != fen_q) begin
				// Mode change drops a partial group
				acc_q <= 12'h000;
				cnt_q <= 2'h0;
			end else if (!filt_en) begin
				if (in_meas.valid) begin
					out_q <= in_meas;
				end
			end else if (group_end) begin
				// Average of four stays inside the value range
				out_q.valid <= 1'b1;
				out_q.value <= acc_sum[11:2];
				acc_q       <= 12'h000;
				cnt_q       <= 2'h0;
			end else if (in_meas.valid) begin
				acc_q <= acc_sum;
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end

	assign out_meas = out_q;
endmodule

// *** mlsd_monitor.sv ***
// Port-level checker for the load readout top
`timescale 1ns/1ps
module mlsd_monitor #(
	parameter int ADDR_W = 8                    // Register address width
) (
	input wire logic              MCLK,
	input wire logic              RSTN,
	input wire logic              FULLSTEP,
	input wire logic [9:0]        LOAD_VALUE,
	input wire logic              STALL_OUT,
	input wire logic              IRQ,
	input wire logic              S_AXI_AWVALID,
	input wire logic              S_AXI_AWREADY,
	input wire logic              S_AXI_WVALID,
	input wire logic              S_AXI_WREADY,
	input wire logic              S_AXI_BVALID,
	input wire logic              S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic              S_AXI_ARVALID,
	input wire logic              S_AXI_ARREADY,
	input wire logic [31:0]       S_AXI_RDATA,
	input wire logic [1:0]        S_AXI_RRESP,
	input wire logic              S_AXI_RVALID,
	input wire logic              S_AXI_RREADY
);
	// Every check on the rising edge, quiet in reset
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	// Handshake events and the unmapped read decode
	wire wr_go  = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	wire rd_go  = S_AXI_ARVALID && S_AXI_ARREADY;
	wire rd_bad = S_AXI_ARADDR[ADDR_W-1:4] != '0; // Beyond the four words

	a_wr_answer_delay: assert property (wr_go |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
		else $error("write response not two cycles after handshake");
	a_wr_channel_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write accepted while response pending");
	a_wr_answer_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response repeated");
	a_rd_answer_delay: assert property (rd_go |=> S_AXI_RVALID)
		else $error("read data not one cycle after handshake");
	a_rd_channel_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read accepted while data pending");
	a_rd_unmapped_error: assert property (rd_go && rd_bad |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
		else $error("unmapped read not refused");
	a_rd_mapped_okay: assert property (rd_go && !rd_bad |=> S_AXI_RRESP == 2'h0)
		else $error("mapped read refused");
	a_load_step_cause: assert property (!$stable(LOAD_VALUE) |-> $past(FULLSTEP, 3))
		else $error("load value changed without a full step");
	a_stall_step_cause: assert property (!$stable(STALL_OUT) |-> $past(FULLSTEP, 3))
		else $error("stall output changed without a full step");
	a_stall_at_zero: assert property (STALL_OUT |-> LOAD_VALUE == 10'h000)
		else $error("stall output high with nonzero load");

	// Main scenarios reached
	c_stall_rise: cover property ($rose(STALL_OUT));
	c_irq_rise: cover property ($rose(IRQ));
	c_rd_refused: cover property (rd_go && rd_bad);
endmodule

bind mlsd_top mlsd_monitor #(.ADDR_W(ADDR_W)) mon_u (.MCLK, .RSTN, .FULLSTEP, .LOAD_VALUE, .STALL_OUT, .IRQ,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY,
	.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);

// *** mlsd_front_model.sv ***
// Behavioural sensing front end issuing full-step pulses
`timescale 1ns/1ps
module mlsd_front_model (
	input  wire logic       clk,
	input  wire logic       go,        // Request one full step
	input  wire logic [3:0] lag,       // Extra cycles before the pulse
	input  wire logic [9:0] raw,       // Measurement to present
	output logic [9:0]      raw_load,  // Measurement bus
	output logic            fullstep   // One-cycle full-step pulse
);
	logic [4:0] cnt_q = 5'h00;         // Cycles left until the pulse
	logic [9:0] val_q = 10'h000;       // Latched measurement
	initial raw_load = 10'h000;
	initial fullstep = 1'b0;
	// Sample valid only in the pulse cycle; bus toggles otherwise
	always @(posedge clk) begin
		fullstep <= 1'b0;
		raw_load <= ~raw_load;
		if (go) begin
			cnt_q <= {1'b0, lag} + 5'h01;
			val_q <= raw;
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
			if (cnt_q == 5'h01) begin
				fullstep <= 1'b1;
				raw_load <= val_q;
			end
		end
	end
endmodule

// *** test_motor_load_stall_detect.sv ***
// Self-checking bench for the load readout block
`timescale 1ns/1ps
module test_motor_load_stall_detect;
	localparam int TW = 16;              // Load counts per threshold step
	localparam logic [9:0] STALL_LIM = 10'h190; // Software stall limit
	logic        MCLK = 1'b0, RSTN = 1'b0;
	logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic [3:0]  S_AXI_WSTRB = 4'hF;
	logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
	logic [9:0]  RAW_LOAD, LOAD_VALUE, fraw = 10'h000;
	logic        FULLSTEP, STALL_OUT, IRQ, fgo = 1'b0;
	logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	logic [31:0] S_AXI_RDATA;
	logic [3:0]  flag = 4'h0;
	logic [33:0] rq[$];                  // Expected read response and data
	logic [1:0]  bq[$];                  // Expected write responses
	logic [15:0] lf = 16'hE7F0;          // Random source state
	logic [6:0]  tt [5] = '{7'h00, 7'h3F, 7'h40, 7'h7F, 7'h05};
	int          error_cnt = 0, comparisons = 0;

	mlsd_top #(.ADDR_W(8), .THR_WEIGHT(TW)) dut_u (.MCLK, .RSTN, .RAW_LOAD, .FULLSTEP, .LOAD_VALUE, .STALL_OUT,
		.IRQ, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
		.S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
		.S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
	mlsd_front_model fe_u (.clk(MCLK), .go(fgo), .lag(flag), .raw(fraw), .raw_load(RAW_LOAD), .fullstep(FULLSTEP));

	always #4 MCLK = ~MCLK;

	// Shift the random source and return ten bits
	function automatic logic [9:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf[9:0];
	endfunction

	// Offset by the signed threshold, clamp to full scale
	function automatic logic [9:0] sc(input logic [9:0] r, input logic [6:0] t);
		int x;
		x = int'(r) + TW * int'($signed(t));
		return (x < 0) ? 10'h000 : (x > 1023) ? 10'h3FF : 10'(x);
	endfunction

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask

	// Register write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		// Each channel is released at its own handshake
		fork
			begin
				do @(posedge MCLK); while (!S_AXI_AWREADY);
				S_AXI_AWVALID <= 1'b0;
			end
			begin
				do @(posedge MCLK); while (!S_AXI_WREADY);
				S_AXI_WVALID <= 1'b0;
			end
		join
		do @(posedge MCLK); while (!S_AXI_BVALID);
		S_AXI_BREADY <= 1'b0;
		@(posedge MCLK);
	endtask

	// Register read; the watcher compares the answer
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do @(posedge MCLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'b0;
		do @(posedge MCLK); while (!S_AXI_RVALID);
		S_AXI_RREADY <= 1'b0;
		@(posedge MCLK);
	endtask

	// One full step; returns once the report is visible
	task automatic step(input logic [9:0] r, input logic [3:0] l);
		fgo <= 1'b1;
		fraw <= r;
		flag <= l;
		@(posedge MCLK);
		fgo <= 1'b0;
		do @(posedge MCLK); while (!FULLSTEP);
		repeat (4) @(posedge MCLK);
	endtask

	// Watcher: oldest note against each bus answer
	always @(posedge MCLK) begin
		if (S_AXI_RVALID && S_AXI_RREADY) chk({S_AXI_RRESP, S_AXI_RDATA}, rq.pop_front());
		if (S_AXI_BVALID && S_AXI_BREADY) chk({32'h0, S_AXI_BRESP}, {32'h0, bq.pop_front()});
	end

	task automatic results();
		if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge MCLK);
		error_cnt++;
		results();
	end

	initial begin
		logic [9:0] v, r, pv;
		logic [6:0] t;
		logic       s, ps;
		int         sum;
		ps = 1'b0;
		repeat (10) @(posedge MCLK);
		RSTN <= 1'b1;
		repeat (2) @(posedge MCLK);
		rd(8'h00, 34'h0);
		// Load word is read-only: write is answered but ignored
		wr(8'h04, 32'h0001_03FF, 2'h0);
		rd(8'h04, 34'h0);
		rd(8'h08, 34'h0);
		rd(8'h0C, 34'h0);
		rd(8'h10, {2'h2, 32'h0});
		wr(8'h14, 32'h1, 2'h2);
		wr(8'h0C, 32'h3, 2'h0);
		// Threshold sweep incl. both saturation ends
		for (int i = 0; i < 5; i++) begin
			t = tt[i];
			r = (i == 1) ? 10'h3F0 : (i == 2) ? 10'h005 : rnd();
			wr(8'h00, {25'h0, t}, 2'h0);
			rd(8'h00, {27'h0, t});
			step(r, 4'(rnd()));
			v = sc(r, t);
			s = (v == 10'h000);
			chk({STALL_OUT, LOAD_VALUE}, {s, v});
			chk(LOAD_VALUE <= STALL_LIM, v <= STALL_LIM);
			chk(IRQ, 1'b1);
			rd(8'h04, {17'h0, s, 6'h0, v});
			rd(8'h08, {32'h0, s & !ps, 1'b1});
			@(posedge MCLK);
			chk(IRQ, 1'b0);
			ps = s;
		end
		// Masked event leaves the interrupt low
		wr(8'h0C, 32'h0, 2'h0);
		step(10'h0C8, 4'h3);
		pv = sc(10'h0C8, 7'h05);
		chk(IRQ, 1'b0);
		rd(8'h08, 34'h1);
		// Filtered mode: one report per four steps
		// Lane one only: filter bit set, threshold kept
		S_AXI_WSTRB <= 4'h2;
		wr(8'h00, 32'h100, 2'h0);
		S_AXI_WSTRB <= 4'hF;
		sum = 0;
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			sum += sc(r, 7'h05);
			step(r, 4'(k));
			v = (k == 3) ? 10'(sum >> 2) : pv;
			chk({STALL_OUT, LOAD_VALUE}, {v == 10'h000, v});
		end
		rd(8'h00, 34'h105);
		results();
	end
endmodule
